// ===== hdl/ljc_pkg.sv
package ljc_pkg;
	// instruction function codes seen on the program memory port
	localparam logic [7:0] LJC_OP_END = 8'h01; // program end, closes the scan
	localparam logic [7:0] LJC_OP_INTERLOCK_OPEN = 8'h02;
	localparam logic [7:0] LJC_OP_INTERLOCK_CLOSE = 8'h03;
	localparam logic [7:0] LJC_OP_SKIP_BEGIN = 8'h04;
	localparam logic [7:0] LJC_OP_SKIP_END = 8'h05;
	localparam logic [7:0] LJC_OP_LOAD = 8'h10; // load_condition
	localparam logic [7:0] LJC_OP_LOAD_NOT = 8'h11;
	localparam logic [7:0] LJC_OP_AND = 8'h12;
	localparam logic [7:0] LJC_OP_AND_NOT = 8'h13;
	localparam logic [7:0] LJC_OP_OR = 8'h14;
	localparam logic [7:0] LJC_OP_OR_NOT = 8'h15;
	localparam logic [7:0] LJC_OP_OUT_BIT = 8'h16; // right-hand bit output
	localparam logic [7:0] LJC_OP_OUT_TEMP = 8'h17; // store into temp_condition_bit
	localparam logic [7:0] LJC_OP_LOAD_TEMP = 8'h18; // load from temp_condition_bit
	localparam logic [7:0] LJC_OP_RIGHT = 8'h19; // any other right-hand instruction

	// skip numbers: 00 is the shared search kind, 01..49 are unique
	localparam logic [7:0] LJC_SKIP_SHARED = 8'h00;
	localparam logic [7:0] LJC_SKIP_MAX = 8'h31;
	localparam int LJC_SKIP_ENTRIES = 50;

	// temp_condition_bit count, numbered 0..7
	localparam int LJC_TEMP_BITS = 8;
	localparam logic [7:0] LJC_TEMP_MAX = 8'h07;

	// reset values
	localparam logic LJC_COND_RST = 1'b0;
	localparam logic LJC_ILOK_RST = 1'b1;

	// sequencer states, one-hot
	typedef enum logic [2:0] {
		LJC_ST_IDLE = 3'b001,
		LJC_ST_FETCH = 3'b010,
		LJC_ST_LOOKUP = 3'b100
	} ljc_state_type;
endpackage

// ===== hdl/ljc_skip_table.sv
`timescale 1ns/100ps
`default_nettype none
module ljc_skip_table
	import ljc_pkg::*;
#(
	parameter int DEPTH = 64,
	parameter int ADDR_W = 16
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// forget every entry when the program is edited
	input wire logic clear,
	// write side: a skip_end seen at an address
	input wire logic wr_en,
	input wire logic [5:0] wr_idx,
	input wire logic [ADDR_W-1:0] wr_addr,
	// read side: data one cycle after the index
	input wire logic [5:0] rd_idx,
	output logic [ADDR_W-1:0] rd_addr,
	output logic rd_hit
);
	// entries need a 6-bit index and room for every unique number
	if (DEPTH < LJC_SKIP_ENTRIES || DEPTH > 64) begin : g_depth_check
		$error("skip table depth out of range");
	end

	// address store, no reset needed since valid bits guard it
	logic [ADDR_W-1:0] mem_r [DEPTH];
	// one valid bit per number
	logic [DEPTH-1:0] valid_r;

	// remember where each numbered skip_end lives
	always_ff @(posedge ref_clk) begin
		if (wr_en) begin
			mem_r[wr_idx] <= wr_addr;
		end
	end

	// valid bits: reset and clear wipe, a write sets
	always_ff @(posedge ref_clk) begin
		if (!reset_n || clear) begin
			valid_r <= '0;
		end else if (wr_en) begin
			valid_r[wr_idx] <= 1'b1;
		end
	end

	// registered read port
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			rd_addr <= '0;
			rd_hit <= 1'b0;
		end else begin
			rd_addr <= mem_r[rd_idx];
			rd_hit <= valid_r[rd_idx] && !clear;
		end
	end
endmodule
`default_nettype wire

// ===== hdl/ljc_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
module ljc_sequencer
	import ljc_pkg::*;
#(
	parameter int ADDR_W = 16,
	parameter int TABLE_DEPTH = 64
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic reset_n,
	// scan control
	input wire logic scan_start,
	input wire logic program_changed,
	output logic scan_busy,
	output logic scan_done_r,
	// program memory fetch
	output logic pm_rd,
	output logic [ADDR_W-1:0] pm_addr_r,
	input wire logic pm_valid,
	input wire logic [7:0] pm_op,
	input wire logic [7:0] pm_operand,
	input wire logic pm_bit_status,
	// right-hand instruction issue
	output logic exe_valid_r,
	output logic [ADDR_W-1:0] exe_addr_r,
	output logic [7:0] exe_op_r,
	output logic exe_cond_r,
	output logic exe_forced_off_r,
	// program fault pulse
	output logic fault_r
);
	if (ADDR_W < 4 || ADDR_W > 24) begin : g_addr_check
		$error("program address width out of range");
	end

	ljc_state_type state_r;
	logic cond_r; // current execution condition
	logic il_ok_r; // AND of all open interlocks
	logic searching_r; // walking forward without executing
	logic [7:0] search_num_r;
	logic last_right_r; // previous instruction ended a line
	logic [LJC_TEMP_BITS-1:0] temp_r;
	logic [LJC_TEMP_BITS-1:0] temp_used_r;
	logic [ADDR_W-1:0] tbl_addr;
	logic tbl_hit;

	// decode helpers
	logic ins_fire, fire_norm, eff, right_op, new_block, temp_sel, skip_taken;
	logic [2:0] temp_idx;
	assign ins_fire = (state_r == LJC_ST_FETCH) && pm_valid;
	assign fire_norm = ins_fire && !searching_r;
	assign eff = cond_r & il_ok_r;
	assign right_op = (pm_op == LJC_OP_OUT_BIT) || (pm_op == LJC_OP_RIGHT);
	assign temp_idx = pm_operand[2:0];
	assign temp_sel = temp_r[temp_idx];
	assign skip_taken = fire_norm && (pm_op == LJC_OP_SKIP_BEGIN) && !eff;
	assign new_block = fire_norm && (pm_op == LJC_OP_LOAD || pm_op == LJC_OP_LOAD_NOT)
		&& last_right_r;
	// handshake outputs straight from state
	assign pm_rd = (state_r == LJC_ST_FETCH);
	assign scan_busy = (state_r != LJC_ST_IDLE);

	// learned skip_end addresses make numbered skips direct
	ljc_skip_table #(.DEPTH(TABLE_DEPTH), .ADDR_W(ADDR_W)) u_table (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.clear(program_changed),
		.wr_en(ins_fire && pm_op == LJC_OP_SKIP_END && pm_operand != LJC_SKIP_SHARED
			&& pm_operand <= LJC_SKIP_MAX),
		.wr_idx(pm_operand[5:0]),
		.wr_addr(pm_addr_r),
		.rd_idx(pm_operand[5:0]),
		.rd_addr(tbl_addr),
		.rd_hit(tbl_hit)
	);

	// sequencing: state and program address
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			state_r <= LJC_ST_IDLE;
			pm_addr_r <= '0;
		end else begin
			case (state_r)
				LJC_ST_IDLE: begin
					if (scan_start) begin
						state_r <= LJC_ST_FETCH;
						pm_addr_r <= '0;
					end
				end
				LJC_ST_FETCH: begin
					if (ins_fire) begin
						if (pm_op == LJC_OP_END) begin
							state_r <= LJC_ST_IDLE;
						end else if (skip_taken && pm_operand != LJC_SKIP_SHARED
							&& pm_operand <= LJC_SKIP_MAX) begin
							state_r <= LJC_ST_LOOKUP;
						end else begin
							pm_addr_r <= pm_addr_r + 1'b1;
						end
					end
				end
				LJC_ST_LOOKUP: begin
					// hit: jump past the known end; miss: search from here
					state_r <= LJC_ST_FETCH;
					if (tbl_hit) begin
						pm_addr_r <= tbl_addr + 1'b1;
					end else begin
						pm_addr_r <= pm_addr_r + 1'b1;
					end
				end
				default: begin
					state_r <= LJC_ST_IDLE;
				end
			endcase
		end
	end

	// forward search for the matching skip_end
	always_ff @(posedge ref_clk) begin
		if (!reset_n || (state_r == LJC_ST_IDLE)) begin
			searching_r <= 1'b0;
			search_num_r <= LJC_SKIP_SHARED;
		end else if (state_r == LJC_ST_LOOKUP) begin
			// a table miss, first scan after an edit, falls back to a search
			searching_r <= !tbl_hit;
		end else if (skip_taken && pm_operand <= LJC_SKIP_MAX) begin
			searching_r <= (pm_operand == LJC_SKIP_SHARED);
			search_num_r <= pm_operand;
		end else if (ins_fire && searching_r && pm_op == LJC_OP_SKIP_END
			&& pm_operand == search_num_r) begin
			searching_r <= 1'b0;
		end
	end

	// execution condition: one bit, loads replace, logic combines
	always_ff @(posedge ref_clk) begin
		if (!reset_n || (state_r == LJC_ST_IDLE)) begin
			cond_r <= LJC_COND_RST;
		end else if (fire_norm) begin
			case (pm_op)
				LJC_OP_LOAD: cond_r <= pm_bit_status;
				LJC_OP_LOAD_NOT: cond_r <= !pm_bit_status;
				LJC_OP_AND: cond_r <= cond_r & pm_bit_status;
				LJC_OP_AND_NOT: cond_r <= cond_r & !pm_bit_status;
				LJC_OP_OR: cond_r <= cond_r | pm_bit_status;
				LJC_OP_OR_NOT: cond_r <= cond_r | !pm_bit_status;
				LJC_OP_LOAD_TEMP: cond_r <= temp_sel;
				default: cond_r <= cond_r;
			endcase
		end
	end

	// interlock gate; a skip search leaves it alone
	always_ff @(posedge ref_clk) begin
		if (!reset_n || (state_r == LJC_ST_IDLE)) begin
			il_ok_r <= LJC_ILOK_RST;
		end else if (fire_norm && pm_op == LJC_OP_INTERLOCK_OPEN) begin
			il_ok_r <= il_ok_r & cond_r;
		end else if (fire_norm && pm_op == LJC_OP_INTERLOCK_CLOSE) begin
			il_ok_r <= 1'b1;
		end
	end

	// line tracking for block boundaries
	always_ff @(posedge ref_clk) begin
		if (!reset_n || (state_r == LJC_ST_IDLE)) begin
			last_right_r <= 1'b1;
		end else if (fire_norm) begin
			last_right_r <= right_op || (pm_op == LJC_OP_INTERLOCK_OPEN)
				|| (pm_op == LJC_OP_INTERLOCK_CLOSE) || (pm_op == LJC_OP_SKIP_BEGIN)
				|| (pm_op == LJC_OP_SKIP_END);
		end
	end

	// temp bits: one generate slice per bit
	for (genvar i = 0; i < LJC_TEMP_BITS; i++) begin : g_temp
		always_ff @(posedge ref_clk) begin
			if (!reset_n) begin
				temp_r[i] <= 1'b0;
				temp_used_r[i] <= 1'b0;
			end else if (state_r == LJC_ST_IDLE || new_block) begin
				temp_used_r[i] <= 1'b0;
			end else if (fire_norm && pm_op == LJC_OP_OUT_TEMP && temp_idx == i
				&& pm_operand <= LJC_TEMP_MAX) begin
				temp_r[i] <= cond_r;
				temp_used_r[i] <= 1'b1;
			end
		end
	end

	// issue right-hand instructions with the gated condition
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			exe_valid_r <= 1'b0;
			exe_addr_r <= '0;
			exe_op_r <= '0;
			exe_cond_r <= 1'b0;
			exe_forced_off_r <= 1'b0;
		end else begin
			exe_valid_r <= fire_norm && right_op;
			if (fire_norm && right_op) begin
				exe_addr_r <= pm_addr_r;
				exe_op_r <= pm_op;
				exe_cond_r <= eff;
				exe_forced_off_r <= !il_ok_r;
			end
		end
	end

	// scan end and program faults, one-cycle pulses
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			scan_done_r <= 1'b0;
			fault_r <= 1'b0;
		end else begin
			scan_done_r <= ins_fire && (pm_op == LJC_OP_END);
			fault_r <= (skip_taken && pm_operand > LJC_SKIP_MAX)
				|| (fire_norm && pm_op == LJC_OP_OUT_TEMP
				&& (pm_operand > LJC_TEMP_MAX || temp_used_r[temp_idx]));
		end
	end

	// checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	a_il_forced_off: assert property (exe_valid_r && exe_forced_off_r |-> !exe_cond_r)
		else $error("forced section issued an ON condition");
	a_il_and_cond: assert property (fire_norm && right_op |=>
		exe_valid_r && exe_cond_r == ($past(cond_r) && $past(il_ok_r)))
		else $error("issued condition is not interlock AND line");
	a_ilc_resume: assert property (fire_norm && pm_op == LJC_OP_INTERLOCK_CLOSE |=> il_ok_r)
		else $error("close did not restore evaluation");
	a_il_nest_hold: assert property (!il_ok_r && fire_norm
		&& pm_op == LJC_OP_INTERLOCK_OPEN |=> !il_ok_r)
		else $error("inner open released an OFF section");
	a_skip_pass: assert property (fire_norm && pm_op == LJC_OP_SKIP_BEGIN && eff
		|=> !searching_r && pm_addr_r == $past(pm_addr_r) + 1'b1)
		else $error("untaken skip did not fall through");
	a_skip_quiet: assert property (searching_r && ins_fire |=> !exe_valid_r)
		else $error("instruction issued inside a skip");
	a_jnum_range: assert property (skip_taken && pm_operand > LJC_SKIP_MAX |=> fault_r)
		else $error("bad skip number not flagged");
	a_zero_search: assert property (skip_taken && pm_operand == LJC_SKIP_SHARED
		|=> searching_r && search_num_r == LJC_SKIP_SHARED)
		else $error("shared skip did not start a search");
	a_lookup_hit: assert property (state_r == LJC_ST_LOOKUP && tbl_hit
		|=> pm_addr_r == $past(tbl_addr) + 1'b1 && !searching_r)
		else $error("numbered skip missed its end");
	a_search_end: assert property (searching_r && ins_fire && pm_op == LJC_OP_END
		|=> scan_done_r && state_r == LJC_ST_IDLE)
		else $error("unmatched search did not end the scan");
	a_temp_restore: assert property (fire_norm && pm_op == LJC_OP_LOAD_TEMP
		|=> cond_r == $past(temp_sel))
		else $error("temp bit not restored");
	a_cond_and: assert property (fire_norm && pm_op == LJC_OP_AND
		|=> cond_r == ($past(cond_r) && $past(pm_bit_status)))
		else $error("AND did not combine condition");

	c_forced_issue: cover property (exe_valid_r && exe_forced_off_r);
	c_shared_skip: cover property (skip_taken && pm_operand == LJC_SKIP_SHARED);
	c_table_hit: cover property (state_r == LJC_ST_LOOKUP && tbl_hit);
	c_scan_done: cover property (scan_done_r);
endmodule
`default_nettype wire

// ===== tb/ljc_pm_model.sv
`timescale 1ns/100ps
`default_nettype none
// program memory: one word per instruction, answered in the fetch cycle
module ljc_pm_model
	import ljc_pkg::*;
(
	// clock
	input wire logic ref_clk,
	// fetch request from the sequencer
	input wire logic pm_rd,
	input wire logic [15:0] pm_addr_r,
	// bench choice: answer only every other cycle
	input wire logic slow,
	// fetched word
	output logic pm_valid,
	output logic [7:0] pm_op,
	output logic [7:0] pm_operand,
	output logic pm_bit_status
);
	// word layout: code, operand, bit status; filled by the bench
	logic [16:0] mem [0:63];
	// toggles every cycle; paces slow answers and scrambles idle lines
	logic tog_r = 1'b0;

	// free-running pacing bit; plain always since the variable starts from an initialiser
	always @(posedge ref_clk) begin
		tog_r <= ~tog_r;
	end

	always_comb begin
		pm_valid = pm_rd && (!slow || tog_r);
		if (pm_valid) begin
			{pm_op, pm_operand, pm_bit_status} = mem[pm_addr_r[5:0]];
		end else begin
			// idle lines change every cycle, so a stale word is never trusted
			{pm_op, pm_operand, pm_bit_status} = {17{tog_r}};
		end
	end
endmodule
`default_nettype wire

// ===== tb/ladder_interlock_jump_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module ladder_interlock_jump_control_tb import ljc_pkg::*;;
	// clock, reset and scan control
	logic ref_clk, reset_n, scan_start, program_changed, slow;
	// design outputs and fetch lines
	logic scan_busy, scan_done_r, pm_rd, pm_valid, pm_bit_status;
	logic exe_valid_r, exe_cond_r, exe_forced_off_r, fault_r;
	logic [15:0] pm_addr_r, exe_addr_r;
	logic [7:0] pm_op, pm_operand, exe_op_r;
	// issues of the current scan: address, condition, forced flag
	logic [17:0] iss[$];
	int n_fault, fail_count, n_compared, pc;
	// one row: kind, conditions, skip number, issue count, first issue
	typedef struct packed {
		logic skip;
		logic a;
		logic b;
		logic [7:0] num;
		logic [1:0] n;
		logic [17:0] first;
	} ljc_row_type;
	// every row ends with an unconditional output at address 6
	ljc_row_type rows [9] = '{
		'{1'b0, 1'b0, 1'b0, 8'h00, 2'h2, {16'h3, 2'b01}},
		'{1'b0, 1'b0, 1'b1, 8'h00, 2'h2, {16'h3, 2'b01}},
		'{1'b0, 1'b1, 1'b0, 8'h00, 2'h2, {16'h3, 2'b00}},
		'{1'b0, 1'b1, 1'b1, 8'h00, 2'h2, {16'h3, 2'b10}},
		'{1'b1, 1'b0, 1'b0, 8'h01, 2'h1, {16'h6, 2'b10}},
		'{1'b1, 1'b1, 1'b0, 8'h01, 2'h2, {16'h3, 2'b10}},
		'{1'b1, 1'b0, 1'b0, 8'h31, 2'h1, {16'h6, 2'b10}},
		'{1'b1, 1'b0, 1'b0, 8'h00, 2'h1, {16'h6, 2'b10}},
		'{1'b1, 1'b1, 1'b0, 8'h00, 2'h2, {16'h3, 2'b10}}
	};

	// device under test
	ljc_sequencer #(.ADDR_W(16), .TABLE_DEPTH(64)) u_ljc_sequencer (
		.ref_clk, .reset_n, .scan_start, .program_changed, .scan_busy,
		.scan_done_r, .pm_rd, .pm_addr_r, .pm_valid, .pm_op, .pm_operand,
		.pm_bit_status, .exe_valid_r, .exe_addr_r, .exe_op_r, .exe_cond_r,
		.exe_forced_off_r, .fault_r
	);
	// program memory on the far side
	ljc_pm_model u_ljc_pm_model (
		.ref_clk, .pm_rd, .pm_addr_r, .slow, .pm_valid, .pm_op, .pm_operand,
		.pm_bit_status
	);

	// 125 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	// collect issue and fault pulses one cycle after they were raised
	always @(posedge ref_clk) begin
		if (exe_valid_r === 1'b1) begin
			iss.push_back({exe_addr_r, exe_cond_r, exe_forced_off_r});
		end
		if (fault_r === 1'b1) begin
			n_fault++;
		end
	end

	// one compare for every kind of result, widened to 18 bits
	task automatic chk(input logic [17:0] got, input logic [17:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// append one instruction word
	task automatic put(input logic [7:0] op, input logic [7:0] opd = 8'h00,
		input logic st = 1'b0);
		u_ljc_pm_model.mem[pc] = {op, opd, st};
		pc++;
	endtask

	// a new program makes learned skip_end places stale, so wipe them
	task automatic new_prog();
		@(posedge ref_clk);
		program_changed <= 1'b1;
		@(posedge ref_clk);
		program_changed <= 1'b0;
		pc = 0;
	endtask

	// start one scan and wait, bounded, for its end
	task automatic run_scan();
		int i;
		iss.delete();
		n_fault = 0;
		@(posedge ref_clk);
		scan_start <= 1'b1;
		@(posedge ref_clk);
		scan_start <= 1'b0;
		for (i = 0; i < 300; i++) begin
			@(negedge ref_clk);
			// busy from the first fetch cycle
			if (i == 0) begin
				chk({17'h0, scan_busy}, 18'h1);
			end
			if (scan_done_r === 1'b1) begin
				// back in idle once the program end is taken
				chk({17'h0, scan_busy}, 18'h0);
				break;
			end
		end
		if (i == 300) begin
			fail_count++;
			$display("BAD t=%0t scan never ended", $time);
			finish_test();
		end
	endtask

	// counts, verdict, end of run
	task automatic finish_test();
		$display("compared %0d mismatched %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// main sequence
	initial begin
		reset_n = 1'b0;
		scan_start = 1'b0;
		program_changed = 1'b0;
		slow = 1'b0;
		fail_count = 0;
		n_compared = 0;
		pc = 0;
		for (int k = 0; k < 64; k++) begin
			u_ljc_pm_model.mem[k] = {LJC_OP_END, 9'h000};
		end
		@(negedge ref_clk);
		// quiet outputs while held in reset
		chk({16'h0, scan_busy, pm_rd}, 18'h0);
		chk({16'h0, exe_valid_r, fault_r}, 18'h0);
		@(posedge ref_clk);
		reset_n <= 1'b1;
		// table rows; each program scanned twice, the second from learned ends where a numbered skip is taken
		foreach (rows[r]) begin
			new_prog();
			slow <= r[0];
			put(LJC_OP_LOAD, 8'h00, rows[r].a);
			put(rows[r].skip ? LJC_OP_SKIP_BEGIN : LJC_OP_INTERLOCK_OPEN, rows[r].num);
			put(LJC_OP_LOAD, 8'h00, rows[r].skip | rows[r].b);
			put(LJC_OP_OUT_BIT);
			put(rows[r].skip ? LJC_OP_SKIP_END : LJC_OP_INTERLOCK_CLOSE, rows[r].num);
			put(LJC_OP_LOAD, 8'h00, 1'b1);
			put(LJC_OP_OUT_BIT);
			put(LJC_OP_END);
			repeat (2) begin
				run_scan();
				chk(18'(iss.size()), 18'(rows[r].n));
				chk(iss[0], rows[r].first);
				chk(iss[iss.size() - 1], {16'h6, 2'b10});
				chk(18'(n_fault), 18'h0);
			end
			$display("row %0d done", r);
		end
		// nested interlocks, then a temp bit saved, reused and restored
		new_prog();
		put(LJC_OP_LOAD, 8'h00, 1'b1);
		put(LJC_OP_INTERLOCK_OPEN);
		put(LJC_OP_LOAD, 8'h00, 1'b1);
		put(LJC_OP_OUT_BIT);
		put(LJC_OP_LOAD);
		put(LJC_OP_INTERLOCK_OPEN);
		put(LJC_OP_LOAD, 8'h00, 1'b1);
		put(LJC_OP_OUT_BIT);
		put(LJC_OP_INTERLOCK_CLOSE);
		put(LJC_OP_LOAD, 8'h00, 1'b1);
		put(LJC_OP_OUT_BIT);
		put(LJC_OP_OUT_TEMP);
		put(LJC_OP_AND);
		put(LJC_OP_OUT_BIT);
		put(LJC_OP_LOAD_TEMP);
		put(LJC_OP_OUT_BIT);
		put(LJC_OP_OUT_TEMP);
		put(LJC_OP_END);
		run_scan();
		chk(18'(iss.size()), 18'h5);
		chk(iss[0], {16'h3, 2'b10});
		chk(iss[1], {16'h7, 2'b01});
		chk(iss[2], {16'ha, 2'b10});
		chk(iss[3], {16'hd, 2'b00});
		chk(iss[4], {16'hf, 2'b10});
		chk(18'(n_fault), 18'h1);
		$display("nested interlock and temp test done");
		// shared 00 skips, an out-of-range number, an unmatched 00 search
		new_prog();
		slow <= 1'b1;
		put(LJC_OP_LOAD);
		put(LJC_OP_SKIP_BEGIN);
		put(LJC_OP_LOAD, 8'h00, 1'b1);
		put(LJC_OP_OUT_BIT);
		put(LJC_OP_SKIP_BEGIN);
		put(LJC_OP_OUT_BIT);
		put(LJC_OP_SKIP_END);
		put(LJC_OP_LOAD, 8'h00, 1'b1);
		put(LJC_OP_OUT_BIT);
		put(LJC_OP_LOAD);
		put(LJC_OP_SKIP_BEGIN, 8'h32);
		put(LJC_OP_LOAD, 8'h00, 1'b1);
		put(LJC_OP_OUT_BIT);
		put(LJC_OP_LOAD);
		put(LJC_OP_SKIP_BEGIN);
		put(LJC_OP_LOAD, 8'h00, 1'b1);
		put(LJC_OP_OUT_BIT);
		put(LJC_OP_END);
		run_scan();
		chk(18'(iss.size()), 18'h2);
		chk(iss[0], {16'h8, 2'b10});
		chk(iss[1], {16'hc, 2'b10});
		chk(18'(n_fault), 18'h1);
		$display("shared skip test done");
		// outer interlock OFF around an inner ON one, inverted and OR loads
		new_prog();
		put(LJC_OP_LOAD_NOT, 8'h00, 1'b1);
		put(LJC_OP_OR_NOT, 8'h00, 1'b1);
		put(LJC_OP_INTERLOCK_OPEN);
		put(LJC_OP_LOAD_NOT);
		put(LJC_OP_INTERLOCK_OPEN);
		put(LJC_OP_OR);
		put(LJC_OP_RIGHT);
		put(LJC_OP_INTERLOCK_CLOSE);
		put(LJC_OP_LOAD_NOT);
		put(LJC_OP_AND_NOT, 8'h00, 1'b1);
		put(LJC_OP_OR_NOT);
		put(LJC_OP_RIGHT);
		put(LJC_OP_END);
		run_scan();
		chk(18'(iss.size()), 18'h2);
		chk(iss[0], {16'h6, 2'b01});
		chk(iss[1], {16'hb, 2'b10});
		chk({10'h0, exe_op_r}, {10'h0, LJC_OP_RIGHT});
		$display("outer OFF interlock test done");
		finish_test();
	end
endmodule
`default_nettype wire
